// File: dpc_pkg.sv
// Package with register map, field positions and reset values of the dual port block.
package dpc_pkg;

  // ****************************************************************
  // Register indices (the offsets are not all multiples of four,
  // so each is an index and the byte address is four times it).
  // ****************************************************************
  localparam logic [7:0] NARROW_PORT_IDX          = 8'h05;
  localparam logic [7:0] WIDE_PORT_IDX            = 8'h06;
  localparam logic [7:0] CORE_OPTION_IDX          = 8'h81;
  localparam logic [7:0] NARROW_PORT_DIR_IDX      = 8'h85;
  localparam logic [7:0] WIDE_PORT_DIR_IDX        = 8'h86;
  localparam logic [7:0] INTERRUPT_CONTROL_IDX    = 8'h0B;

  localparam int NARROW_WIDTH = 5;
  localparam int WIDE_WIDTH   = 8;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int PULLUP_DISABLE_BIT = 7;
  localparam int CHANGE_FLAG_BIT    = 0;
  localparam int CHANGE_ENABLE_BIT  = 3;
  localparam int OPEN_DRAIN_BIT     = 4;
  localparam int EXT_IRQ_BIT        = 0;
  localparam int PROG_CLOCK_BIT     = 6;
  localparam int PROG_DATA_BIT      = 7;
  localparam int MONITOR_LOW_BIT    = 4;

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [7:0] OPTION_RESET       = 8'hFF;
  localparam logic [4:0] NARROW_DIR_RESET   = 5'h1F;
  localparam logic [7:0] WIDE_DIR_RESET     = 8'hFF;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_RESET       = 8'h00;

endpackage : dpc_pkg

// File: dpc_change_detect.sv
// Change detector for the monitored upper pins of the wide port.
`timescale 1ns/1ps
`default_nettype none

module dpc_change_detect #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pins_i,
  input  wire logic [WIDTH-1:0] dir_i,
  input  wire logic             access_i,
  output logic                  mismatch_o
);

  logic [WIDTH-1:0] reference;
  logic [WIDTH-1:0] differ;

  // Reference is captured from the pins on any access of the port.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reference <= '0;
    end else if (access_i) begin
      reference <= pins_i; // [RL14] [RL17]
    end
  end

  // Output pins are masked out; the access cycle itself reports no mismatch,
  // which is the window in which a change may be missed.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign differ[g] = dir_i[g] & (pins_i[g] ^ reference[g]); // [RL13] [RL14]
    end
  endgenerate

  assign mismatch_o = (|differ) & ~access_i; // [RL15] [RL19]

endmodule : dpc_change_detect

`default_nettype wire

// File: dpc_ports.sv
// Two general purpose ports with direction; the wide port adds pull-ups and change detection.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: Narrow port has five latch and direction bits.
// RL2: Top narrow pin is open drain, timer clock.
// RL3: Direction one floats pin, zero drives latch.
// RL4: Port reads return pins; writes load latch.
// RL5: Writes store whole port, inputs take pins.
// RL6: Every reset makes all pins inputs.
// RL7: Latches undefined at power-on, kept otherwise.
// RL8: Unused narrow port bits read zero.
// RL9: Wide port has eight pins, own direction.
// RL10: Clearing pull-up disable enables all pull-ups.
// RL11: Output pins never get a pull-up.
// RL12: Pull-ups are off after power-on reset.
// RL13: Only upper four input pins are compared.
// RL14: Compare pins against last read reference.
// RL15: OR of mismatches sets change flag.
// RL16: Change flag can wake from sleep.
// RL17: Any wide port access refreshes reference.
// RL18: Mismatch keeps setting flag; software clears.
// RL19: Change during a read may be missed.
// RL20: Lowest wide pin doubles as interrupt input.
// RL21: Top two wide pins are programming lines.
// RL22: Writes commit late, reads sample early.
// RL23: Software should not poll during detection.
// RL24: Change flag reads one until cleared.
// RL25: Pull-up disable bit one turns pull-ups off.
// RL26: Request is flag and enable; wake gets flag.
module dpc_ports #(
  parameter int NARROW_W = dpc_pkg::NARROW_WIDTH,
  parameter int WIDE_W   = dpc_pkg::WIDE_WIDTH
) (
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              por_i,
  // Avalon-MM slave.
  input  wire logic [9:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [3:0]        avs_byteenable_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic      [1:0]        avs_response_o,
  // Narrow port pins.
  input  wire logic [NARROW_W-1:0] narrow_port_i,
  output logic      [NARROW_W-1:0] narrow_port_o,
  output logic      [NARROW_W-1:0] narrow_port_oe_o,
  // Wide port pins.
  input  wire logic [WIDE_W-1:0] wide_port_i,
  output logic      [WIDE_W-1:0] wide_port_o,
  output logic      [WIDE_W-1:0] wide_port_oe_o,
  output logic      [WIDE_W-1:0] wide_port_pullup_o,
  // Side functions of the pins.
  output logic                   timer_external_clock_in_o,
  output logic                   external_interrupt_pin_o,
  output logic                   prog_clock_o,
  output logic                   prog_data_o,
  output logic                   port_change_request_o,
  output logic                   port_change_wake_o
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [NARROW_W-1:0] narrow_port;
  logic [WIDE_W-1:0]   wide_port;
  logic [NARROW_W-1:0] narrow_port_direction;
  logic [WIDE_W-1:0]   wide_port_direction;
  logic [7:0]          core_option_config;
  logic                port_change_flag;
  logic                port_change_enable;
  logic                answer_pending;
  logic                mismatch;

  logic [7:0]  reg_index;
  logic        addr_aligned;
  logic        take_read;
  logic        take_write;
  logic        hit_narrow;
  logic        hit_wide;
  logic        hit_option;
  logic        hit_ndir;
  logic        hit_wdir;
  logic        hit_interrupt_control_reg;
  logic        hit_any;
  logic [7:0]  wdata;
  logic        lane0;
  logic        wide_access;
  logic [31:0] next_readdata;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************

  // A request is answered one cycle after it appears: waitrequest is high in
  // the first cycle and drops in the second, when the access takes effect.
  assign reg_index    = avs_address_i[9:2];
  assign addr_aligned = (avs_address_i[1:0] == 2'b00);
  assign take_read    = avs_read_i & answer_pending;
  assign take_write   = avs_write_i & answer_pending;
  assign hit_narrow   = addr_aligned & (reg_index == dpc_pkg::NARROW_PORT_IDX);
  assign hit_wide     = addr_aligned & (reg_index == dpc_pkg::WIDE_PORT_IDX);
  assign hit_option   = addr_aligned & (reg_index == dpc_pkg::CORE_OPTION_IDX);
  assign hit_ndir     = addr_aligned & (reg_index == dpc_pkg::NARROW_PORT_DIR_IDX);
  assign hit_wdir     = addr_aligned & (reg_index == dpc_pkg::WIDE_PORT_DIR_IDX);
  assign hit_interrupt_control_reg   = addr_aligned & (reg_index == dpc_pkg::INTERRUPT_CONTROL_IDX);
  assign hit_any      = hit_narrow | hit_wide | hit_option | hit_ndir | hit_wdir | hit_interrupt_control_reg;
  assign lane0        = avs_byteenable_i[0];
  assign wdata        = avs_writedata_i[7:0];
  assign wide_access  = (take_read | (take_write & lane0)) & hit_wide; // [RL17]

  // Wait state toggles so that each request sees exactly one wait cycle.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      answer_pending <= 1'b0;
    end else begin
      answer_pending <= (avs_read_i | avs_write_i) & ~answer_pending;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~answer_pending);
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************

  // Port reads return pin levels sampled at the start of the access.
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (1'b1)
      hit_narrow: next_readdata[NARROW_W-1:0] = narrow_port_i; // [RL4] [RL8] [RL22]
      hit_wide:   next_readdata[WIDE_W-1:0]   = wide_port_i;   // [RL4]
      hit_option: next_readdata[7:0]          = core_option_config;
      hit_ndir:   next_readdata[NARROW_W-1:0] = narrow_port_direction; // [RL8]
      hit_wdir:   next_readdata[WIDE_W-1:0]   = wide_port_direction;
      hit_interrupt_control_reg: begin
        next_readdata[dpc_pkg::CHANGE_FLAG_BIT]   = port_change_flag; // [RL24]
        next_readdata[dpc_pkg::CHANGE_ENABLE_BIT] = port_change_enable;
      end
      default:    next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is registered while waitrequest is high and stands when it drops.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~answer_pending) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // Unmapped addresses answer with a slave error, writes there are dropped.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_response_o <= 2'b00;
    end else if ((avs_read_i | avs_write_i) & ~answer_pending) begin
      avs_response_o <= hit_any ? 2'b00 : 2'b10;
    end
  end

  // ****************************************************************
  // Port latches.
  // ****************************************************************

  // The latches have no reset so that they survive warm resets; at power-on
  // their contents are whatever the flops wake up with.
  always_ff @(posedge clock_i) begin
    if (take_write & lane0 & hit_narrow) begin
      // Bits driven as inputs take the pin level, as a read-modify-write would.
      narrow_port <= (wdata[NARROW_W-1:0] & ~narrow_port_direction)
                   | (narrow_port_i & narrow_port_direction); // [RL5] [RL7] [RL1]
    end
  end

  always_ff @(posedge clock_i) begin
    if (take_write & lane0 & hit_wide) begin
      wide_port <= (wdata & ~wide_port_direction)
                 | (wide_port_i & wide_port_direction); // [RL5] [RL7] [RL9]
    end
  end

  // ****************************************************************
  // Direction and option registers.
  // ****************************************************************

  // Direction bits go to all ones on every reset.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      narrow_port_direction <= dpc_pkg::NARROW_DIR_RESET; // [RL6]
      wide_port_direction   <= dpc_pkg::WIDE_DIR_RESET;   // [RL6]
    end else if (take_write & lane0) begin
      if (hit_ndir) begin
        narrow_port_direction <= wdata[NARROW_W-1:0]; // [RL1]
      end
      if (hit_wdir) begin
        wide_port_direction <= wdata; // [RL9]
      end
    end
  end

  // The option register resets with the pull-up disable bit set.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_option_config <= dpc_pkg::OPTION_RESET; // [RL12]
    end else if (take_write & lane0 & hit_option) begin
      core_option_config <= wdata;
    end
  end

  // ****************************************************************
  // Change detection and flag.
  // ****************************************************************
  dpc_change_detect #(
    .WIDTH (4)
  ) u_change (
    .clock_i    (clock_i),
    .reset_n_i  (reset_n_i),
    .pins_i     (wide_port_i[WIDE_W-1:dpc_pkg::MONITOR_LOW_BIT]),
    .dir_i      (wide_port_direction[WIDE_W-1:dpc_pkg::MONITOR_LOW_BIT]),
    .access_i   (wide_access),
    .mismatch_o (mismatch)
  );

  // The mismatch sets the flag every cycle; a set beats a clear in the same
  // cycle, so software must end the mismatch before clearing.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_change_flag   <= 1'b0;
      port_change_enable <= 1'b0;
    end else begin
      if (mismatch) begin
        port_change_flag <= 1'b1; // [RL15] [RL18] [RL24]
      end else if (take_write & lane0 & hit_interrupt_control_reg) begin
        port_change_flag <= wdata[dpc_pkg::CHANGE_FLAG_BIT]; // [RL18]
      end
      if (take_write & lane0 & hit_interrupt_control_reg) begin
        port_change_enable <= wdata[dpc_pkg::CHANGE_ENABLE_BIT];
      end
    end
  end

  // ****************************************************************
  // Pin drivers and side outputs, all registered.
  // ****************************************************************

  // The open drain pin only ever drives low, and only while output and low.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      narrow_port_o    <= '0;
      narrow_port_oe_o <= '0;
    end else begin
      narrow_port_o    <= narrow_port & ~(5'h10); // [RL2]
      narrow_port_oe_o <= ~narrow_port_direction
                        & ~(narrow_port & 5'h10); // [RL2] [RL3]
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wide_port_o        <= '0;
      wide_port_oe_o     <= '0;
      wide_port_pullup_o <= '0;
    end else begin
      wide_port_o    <= wide_port;
      wide_port_oe_o <= ~wide_port_direction; // [RL3]
      wide_port_pullup_o <= wide_port_direction
        & {WIDE_W{~core_option_config[dpc_pkg::PULLUP_DISABLE_BIT]}}; // [RL10] [RL11] [RL25]
    end
  end

  // Pin functions shared with the timer, interrupt and programming logic.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_external_clock_in_o <= 1'b0;
      external_interrupt_pin_o  <= 1'b0;
      prog_clock_o              <= 1'b0;
      prog_data_o               <= 1'b0;
      port_change_request_o     <= 1'b0;
      port_change_wake_o        <= 1'b0;
    end else begin
      timer_external_clock_in_o <= narrow_port_i[dpc_pkg::OPEN_DRAIN_BIT]; // [RL2]
      external_interrupt_pin_o  <= wide_port_i[dpc_pkg::EXT_IRQ_BIT];     // [RL20]
      prog_clock_o              <= wide_port_i[dpc_pkg::PROG_CLOCK_BIT];  // [RL21]
      prog_data_o               <= wide_port_i[dpc_pkg::PROG_DATA_BIT];   // [RL21]
      port_change_request_o     <= port_change_flag & port_change_enable; // [RL26]
      port_change_wake_o        <= port_change_flag; // [RL16] [RL26]
    end
  end

endmodule : dpc_ports

`default_nettype wire

// File: dpc_ports_props.sv
// Concurrent checks on the bus and pin ports of the dual port block.
`timescale 1ns/1ps
`default_nettype none

module dpc_ports_props #(
  parameter int NARROW_W = 5,
  parameter int WIDE_W   = 8
) (
  input wire logic                clock_i,
  input wire logic                reset_n_i,
  input wire logic [9:0]          avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic                avs_waitrequest_o,
  input wire logic [NARROW_W-1:0] narrow_port_i,
  input wire logic [NARROW_W-1:0] narrow_port_o,
  input wire logic [WIDE_W-1:0]   wide_port_i,
  input wire logic [WIDE_W-1:0]   wide_port_oe_o,
  input wire logic [WIDE_W-1:0]   wide_port_pullup_o,
  input wire logic                timer_external_clock_in_o,
  input wire logic                external_interrupt_pin_o,
  input wire logic                prog_clock_o,
  input wire logic                prog_data_o,
  input wire logic                port_change_request_o,
  input wire logic                port_change_wake_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // A completed write to interrupt control is the only way the flag may drop.
  logic clr;
  assign clr = avs_write_i && !avs_waitrequest_o
               && avs_address_i == {dpc_pkg::INTERRUPT_CONTROL_IDX, 2'b00};

  // ****************************************************************
  // Properties.
  // ****************************************************************
  property p_od_low;    narrow_port_o[dpc_pkg::OPEN_DRAIN_BIT] == 1'b0; endproperty
  property p_pull_in;   (wide_port_pullup_o & wide_port_oe_o) == '0; endproperty
  property p_timer;     $past(reset_n_i) |-> timer_external_clock_in_o == $past(narrow_port_i[4]);
  endproperty
  property p_ext_irq;   $past(reset_n_i) |-> external_interrupt_pin_o == $past(wide_port_i[0]);
  endproperty
  property p_prog;      $past(reset_n_i) |-> {prog_data_o, prog_clock_o} == $past(wide_port_i[7:6]);
  endproperty
  property p_req;       port_change_request_o |-> port_change_wake_o; endproperty
  property p_wait_one;  (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  property p_wait_back; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_flag_hold; $fell(port_change_wake_o) |-> $past(clr, 2) || $past(clr, 3); endproperty

  a_od_low: assert property (p_od_low)
    else $error("open drain pin driven high");
  a_pull_in: assert property (p_pull_in)
    else $error("pull-up on an output pin");
  a_timer: assert property (p_timer)
    else $error("timer clock copy wrong");
  a_ext_irq: assert property (p_ext_irq)
    else $error("interrupt pin copy wrong");
  a_prog: assert property (p_prog)
    else $error("programming line copy wrong");
  a_req: assert property (p_req)
    else $error("request without flag");
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer late");
  a_wait_back: assert property (p_wait_back)
    else $error("wait released too long");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");

  c_wake: cover property ($rose(port_change_wake_o));
  c_req:  cover property ($rose(port_change_request_o));
  c_pull: cover property (wide_port_pullup_o != '0);
endmodule : dpc_ports_props

bind dpc_ports dpc_ports_props #(.NARROW_W(NARROW_W), .WIDE_W(WIDE_W)) u_props (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .narrow_port_i(narrow_port_i), .narrow_port_o(narrow_port_o), .wide_port_i(wide_port_i),
  .wide_port_oe_o(wide_port_oe_o), .wide_port_pullup_o(wide_port_pullup_o),
  .timer_external_clock_in_o(timer_external_clock_in_o),
  .external_interrupt_pin_o(external_interrupt_pin_o), .prog_clock_o(prog_clock_o),
  .prog_data_o(prog_data_o), .port_change_request_o(port_change_request_o),
  .port_change_wake_o(port_change_wake_o));

`default_nettype wire

// File: dpc_pins_model.sv
// Board model that resolves the level of every pin of both ports.
`timescale 1ns/1ps
`default_nettype none

module dpc_pins_model (
  input  wire logic       clock_i,
  input  wire logic [4:0] narrow_drive_i,
  input  wire logic [4:0] narrow_oe_i,
  input  wire logic [4:0] narrow_ext_i,
  input  wire logic [4:0] narrow_ext_en_i,
  input  wire logic [7:0] wide_drive_i,
  input  wire logic [7:0] wide_oe_i,
  input  wire logic [7:0] wide_pullup_i,
  input  wire logic [7:0] wide_ext_i,
  input  wire logic [7:0] wide_ext_en_i,
  output logic      [4:0] narrow_pin_o,
  output logic      [7:0] wide_pin_o
);
  // A floating pin toggles each cycle so a stale level is never mistaken for a driven one.
  logic [7:0] float_q = 8'h5A;
  always_ff @(posedge clock_i) begin
    float_q <= ~float_q;
  end

  // Device drive wins, then the board, then the weak pull-up, else the line floats.
  assign narrow_pin_o = (narrow_oe_i & narrow_drive_i)
    | (~narrow_oe_i & ((narrow_ext_en_i & narrow_ext_i) | (~narrow_ext_en_i & float_q[4:0])));
  assign wide_pin_o = (wide_oe_i & wide_drive_i) | (~wide_oe_i & ((wide_ext_en_i & wide_ext_i)
    | (~wide_ext_en_i & (wide_pullup_i | float_q))));
endmodule : dpc_pins_model

`default_nettype wire

// File: dpc_ports_tb.sv
// Self-checking testbench for the dual port block.
`timescale 1ns/1ps
`default_nettype none

module dpc_ports_tb;
  localparam logic [9:0] A_NP = {dpc_pkg::NARROW_PORT_IDX, 2'b00};
  localparam logic [9:0] A_WP = {dpc_pkg::WIDE_PORT_IDX, 2'b00};
  localparam logic [9:0] A_OP = {dpc_pkg::CORE_OPTION_IDX, 2'b00};
  localparam logic [9:0] A_ND = {dpc_pkg::NARROW_PORT_DIR_IDX, 2'b00};
  localparam logic [9:0] A_WD = {dpc_pkg::WIDE_PORT_DIR_IDX, 2'b00};
  localparam logic [9:0] A_IC = {dpc_pkg::INTERRUPT_CONTROL_IDX, 2'b00};
  logic        clock_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        tmr_clk, ext_irq, prog_clk, prog_dat, port_change_request_o, port_change_wake_o;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [1:0]  avs_response_o, r;
  logic [4:0]  narrow_port_i, narrow_port_o, narrow_port_oe_o, n_ext, n_en;
  logic [7:0]  wide_port_i, wide_port_o, wide_port_oe_o, wide_port_pullup_o, w_ext, w_en;
  int          err_total, checks_done;

  dpc_ports uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .por_i(1'b0),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .narrow_port_i(narrow_port_i), .narrow_port_o(narrow_port_o),
    .narrow_port_oe_o(narrow_port_oe_o), .wide_port_i(wide_port_i), .wide_port_o(wide_port_o),
    .wide_port_oe_o(wide_port_oe_o), .wide_port_pullup_o(wide_port_pullup_o),
    .timer_external_clock_in_o(tmr_clk), .external_interrupt_pin_o(ext_irq),
    .prog_clock_o(prog_clk), .prog_data_o(prog_dat),
    .port_change_request_o(port_change_request_o), .port_change_wake_o(port_change_wake_o));

  dpc_pins_model pins (.clock_i(clock_i), .narrow_drive_i(narrow_port_o),
    .narrow_oe_i(narrow_port_oe_o), .narrow_ext_i(n_ext), .narrow_ext_en_i(n_en),
    .wide_drive_i(wide_port_o), .wide_oe_i(wide_port_oe_o), .wide_pullup_i(wide_port_pullup_o),
    .wide_ext_i(w_ext), .wide_ext_en_i(w_en), .narrow_pin_o(narrow_port_i),
    .wide_pin_o(wide_port_i));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  task do_reset;
    reset_n_i <= 1'b0;
    tick(10);
    reset_n_i <= 1'b1;
  endtask : do_reset

  // Holds the request until waitrequest is sampled low, then takes the answer.
  task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, d};
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_total++;
        stop_test();
      end
      @(posedge clock_i);
    end
    q = avs_readdata_o;
    r = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task wait_wake(input logic v);
    int n;
    n = 0;
    while (port_change_wake_o !== v) begin
      n++;
      if (n > 10) begin
        err_total++;
        stop_test();
      end
      @(posedge clock_i);
    end
  endtask : wait_wake

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task t_reset_values;
    bus(0, A_ND, 0); chk(q, 32'h1F, "narrow dir");
    bus(0, A_WD, 0); chk(q, 32'hFF, "wide dir");
    bus(0, A_OP, 0); chk(q, 32'hFF, "option");
    bus(0, A_IC, 0); chk(q, 32'h0, "interrupt_control_reg");
    chk(32'(wide_port_pullup_o), 32'h0, "pullups");
    chk(32'({narrow_port_oe_o, wide_port_oe_o}), 32'h0, "drivers");
    bus(0, 10'h3FC, 0); chk(32'(r), 32'h2, "unmapped");
  endtask : t_reset_values

  task t_narrow;
    bus(1, A_ND, 8'h00);
    bus(1, A_NP, 8'h0F);
    tick(2);
    chk(32'(narrow_port_oe_o), 32'h1F, "narrow oe");
    chk(32'(narrow_port_o), 32'h0F, "narrow out");
    bus(1, A_NP, 8'hFF);
    tick(2);
    chk(32'(narrow_port_oe_o), 32'h0F, "open drain off");
    n_en <= 5'h10;
    n_ext <= 5'h10;
    tick(2);
    bus(0, A_NP, 0); chk(q, 32'h1F, "narrow pins");
    n_ext <= 5'h00;
    tick(2);
    bus(0, A_NP, 0); chk(q, 32'h0F, "pins not latch");
  endtask : t_narrow

  task t_wide;
    w_en <= 8'hF0;
    w_ext <= 8'hA0;
    bus(1, A_OP, 8'h7F);
    bus(1, A_WD, 8'hF0);
    tick(2);
    chk(32'(wide_port_pullup_o), 32'hF0, "pullup inputs");
    bus(1, A_WP, 8'h55);
    tick(1);
    bus(0, A_WP, 0); chk(q, 32'hA5, "wide pins");
    w_en <= 8'h00;
    bus(1, A_WD, 8'h00);
    tick(2);
    chk(32'(wide_port_o), 32'hA5, "rmw latch");
    chk(32'(wide_port_oe_o), 32'hFF, "wide oe");
    chk(32'(wide_port_pullup_o), 32'h0, "pullup outputs");
    bus(1, A_WD, 8'hFF);
    bus(1, A_OP, 8'hFF);
    tick(2);
    chk(32'(wide_port_pullup_o), 32'h0, "pullup disable");
  endtask : t_wide

  // No polling of the wide port while a change is awaited.
  task t_change;
    w_en <= 8'hFF;
    w_ext <= 8'h00;
    bus(0, A_WP, 0);
    bus(1, A_IC, 8'h08);
    tick(3);
    chk(32'(port_change_wake_o), 32'h0, "no change");
    w_ext <= 8'h20;
    wait_wake(1);
    chk(32'(port_change_request_o), 32'h1, "request");
    bus(0, A_IC, 0); chk(q, 32'h09, "flag bit");
    bus(1, A_IC, 8'h00);
    tick(3);
    chk(32'(port_change_wake_o), 32'h1, "flag kept");
    chk(32'(port_change_request_o), 32'h0, "masked");
    bus(0, A_WP, 0);
    bus(1, A_IC, 8'h00);
    tick(3);
    chk(32'(port_change_wake_o), 32'h0, "read clears");
    w_ext <= 8'h60;
    wait_wake(1);
    bus(1, A_WP, 8'h00);
    bus(1, A_IC, 8'h00);
    tick(3);
    chk(32'(port_change_wake_o), 32'h0, "write clears");
    w_ext <= 8'h62;
    tick(4);
    chk(32'(port_change_wake_o), 32'h0, "low pin ignored");
  endtask : t_change

  task t_rereset;
    do_reset();
    bus(0, A_WD, 0); chk(q, 32'hFF, "dir after reset");
    w_en <= 8'h00;
    bus(1, A_WD, 8'h00);
    tick(2);
    chk(32'(wide_port_o), 32'h60, "latch kept");
  endtask : t_rereset

  // ****************************************************************
  // Clock and main sequence.
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  initial begin
    {reset_n_i, avs_read_i, avs_write_i} = 3'h0;
    avs_address_i = 10'h000;
    avs_writedata_i = 32'h0;
    {n_ext, n_en, w_ext, w_en} = 26'h0;
    // The board holds every wide pin low from the start, so no change is flagged early.
    w_en = 8'hFF;
    err_total = 0;
    checks_done = 0;
    do_reset();
    t_reset_values();
    t_narrow();
    t_wide();
    t_change();
    t_rereset();
    stop_test();
  end
endmodule : dpc_ports_tb

`default_nettype wire
